// file: rxpm_map.svh
// Purpose: offsets, field positions, reset values and timing counts of the mode controller
// Assumes: included by bare name wherever a count or offset is needed
// Notes: cycle counts derive from the times and the 250 MHz bus clock
`ifndef RXPM_MAP_SVH
`define RXPM_MAP_SVH

`define RXPM_HCLK_PERIOD_NS 4
`define RXPM_HCLK_KHZ 250000

// enable filter: least time, rounded up
`define RXPM_EN_FILTER_NS 10000
`define RXPM_EN_FILTER_CYC ((`RXPM_EN_FILTER_NS + `RXPM_HCLK_PERIOD_NS - 1) / `RXPM_HCLK_PERIOD_NS)

// clock activity thresholds: longest periods, rounded down
`define RXPM_ACTIVE_KHZ 3000
`define RXPM_ACTIVE_CYC (`RXPM_HCLK_KHZ / `RXPM_ACTIVE_KHZ)
`define RXPM_STANDBY_KHZ 500
`define RXPM_STANDBY_CYC (`RXPM_HCLK_KHZ / `RXPM_STANDBY_KHZ)

// pll multiplication factors
`define RXPM_MULT_ONE_LANE 5'h1E
`define RXPM_MULT_TWO_LANE 5'h0F
`define RXPM_MULT_THREE_LANE 5'h0A

// register offsets
`define RXPM_CTRL_OFS 8'h00
`define RXPM_STATUS_OFS 8'h04
`define RXPM_ERRCNT_OFS 8'h08
`define RXPM_CTRL_HOLD_BIT 0
`define RXPM_STATUS_MODE_LSB 0
`define RXPM_STATUS_LOCK_BIT 2
`define RXPM_STATUS_FAST_BIT 3
`define RXPM_STATUS_CMOK_BIT 4
`define RXPM_CTRL_RESET 1'h0

// payload layout
`define RXPM_VS_BIT 24
`define RXPM_HS_BIT 25
`define RXPM_DE_BIT 26
`define RXPM_STATIC_WORD 27'h3FFFFFF

`endif

// file: rxpm_pkg.sv
// Purpose: types shared by the mode controller, parity checker and register slave
// Assumes: nothing
// Notes: all numbers live in rxpm_map.svh
package rxpm_pkg;

    typedef enum logic [1:0] {
        RXPM_SHUTDOWN = 2'b00,
        RXPM_STANDBY = 2'b01,
        RXPM_ACQUIRE = 2'b10,
        RXPM_RECEIVE = 2'b11
    } rxpm_mode_type;

    typedef struct packed {
        logic en_s1;
        logic en_s2;
        logic clk_s1;
        logic clk_s2;
        logic clk_d;
        logic cmh_s1;
        logic cmh_s2;
        logic cml_s1;
        logic cml_s2;
        logic lock_s1;
        logic lock_s2;
        logic [1:0] ls_s1;
        logic [1:0] ls_s2;
        logic [27:0] word_s1;
        logic [27:0] word_s2;
        logic [11:0] en_cnt;
        logic en_filt;
        logic [9:0] per_cnt;
        logic clk_fast;
        logic clk_slow;
        rxpm_mode_type mode;
        logic [4:0] mult;
    } rxpm_top_state_type;

    typedef struct packed {
        logic [27:0] pend;
        logic pend_ok;
        logic [26:0] out_word;
        logic pclk;
        logic perr;
        logic evt;
    } rxpm_par_state_type;

    typedef struct packed {
        logic ph_valid;
        logic ph_write;
        logic [7:0] ph_addr;
        logic hold_off;
        logic [15:0] errcnt;
        logic [31:0] rdata;
    } rxpm_reg_state_type;

endpackage

// file: rxpm_if.sv
// Purpose: carrier between mode controller, parity checker and register slave
// Assumes: all signals on hclk
// Notes: rise, fall and perr_evt last one hclk cycle, perr lasts until the next link fall
`timescale 1ns/10ps
`default_nettype none
interface rxpm_if;
    import rxpm_pkg::*;
    logic hold_off;
    rxpm_mode_type mode;
    logic lock;
    logic clk_fast;
    logic cm_ok;
    logic receive;
    logic rise;
    logic fall;
    logic [27:0] word;
    logic [26:0] pix;
    logic pclk;
    logic perr;
    logic perr_evt;
    modport ctl (output mode, lock, clk_fast, cm_ok, receive, rise, fall, word, input hold_off, pix, pclk, perr);
    modport par (input receive, rise, fall, word, output pix, pclk, perr, perr_evt);
    modport regs (input mode, lock, clk_fast, cm_ok, perr_evt, output hold_off);
endinterface
`default_nettype wire

// file: rxpm_parity.sv
// Purpose: odd parity check, output hold and error pulse per received word
// Assumes: word stable around the falling link edge
// Notes: word taken at the fall, presented at the next rise
`timescale 1ns/10ps
`default_nettype none
module rxpm_parity
    import rxpm_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // carrier
    rxpm_if.par bus
);
`include "rxpm_map.svh"

    rxpm_par_state_type r, nxt;

    always_comb begin
        nxt = r;
        nxt.evt = 1'b0;
        if (!bus.receive) begin
            // static pattern outside receive, no checking
            nxt.out_word = `RXPM_STATIC_WORD;
            nxt.pclk = 1'b0;
            nxt.perr = 1'b0;
            nxt.pend_ok = 1'b0;
        end else begin
            if (bus.fall) begin
                nxt.pend = bus.word;
                nxt.pend_ok = 1'b1;
                nxt.pclk = 1'b0;
                // half a pixel period after the data transition
                nxt.perr = 1'b0;
            end
            if (bus.rise) begin
                nxt.pclk = 1'b1;
                if (r.pend_ok) begin
                    // 27 payload bits plus parity must sum odd
                    if (^r.pend) begin
                        nxt.out_word = r.pend[26:0];
                    end else begin
                        // bad word dropped, last good word repeats
                        nxt.perr = 1'b1;
                        nxt.evt = 1'b1;
                    end
                end
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r <= '0;
        end else begin
            r <= nxt;
        end
    end

    assign bus.pix = r.out_word;
    assign bus.pclk = r.pclk;
    assign bus.perr = r.perr;
    assign bus.perr_evt = r.evt;

endmodule
`default_nettype wire

// file: rxpm_regs.sv
// Purpose: AHB-Lite slave with control, status and parity error count
// Assumes: single word transfers only
// Notes: zero wait states, response always OKAY
`timescale 1ns/10ps
`default_nettype none
module rxpm_regs
    import rxpm_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // carrier
    rxpm_if.regs bus
);
`include "rxpm_map.svh"

    rxpm_reg_state_type r, nxt;
    logic clr;

    // read data is fixed at the address phase so hrdata comes from a flop
    function automatic logic [31:0] read_of(input logic [7:0] a, input rxpm_reg_state_type s,
                                            input rxpm_mode_type m, input logic lk, input logic fs,
                                            input logic ck);
        logic [31:0] v;
        v = 32'h0;
        case (a)
            `RXPM_CTRL_OFS: v[`RXPM_CTRL_HOLD_BIT] = s.hold_off;
            `RXPM_STATUS_OFS: begin
                v[`RXPM_STATUS_MODE_LSB +: 2] = m;
                v[`RXPM_STATUS_LOCK_BIT] = lk;
                v[`RXPM_STATUS_FAST_BIT] = fs;
                v[`RXPM_STATUS_CMOK_BIT] = ck;
            end
            `RXPM_ERRCNT_OFS: v[15:0] = s.errcnt;
            default: v = 32'h0;
        endcase
        return v;
    endfunction

    always_comb begin
        nxt = r;
        clr = 1'b0;
        if (r.ph_valid && r.ph_write) begin
            if (r.ph_addr == `RXPM_CTRL_OFS) begin
                nxt.hold_off = hwdata[`RXPM_CTRL_HOLD_BIT];
            end
            clr = (r.ph_addr == `RXPM_ERRCNT_OFS);
        end
        // a new error in the clearing cycle is still counted
        if (bus.perr_evt) begin
            nxt.errcnt = clr ? 16'h0001 : r.errcnt + 16'h0001;
        end else if (clr) begin
            nxt.errcnt = 16'h0000;
        end
        nxt.ph_valid = hsel && hready && htrans[1];
        if (nxt.ph_valid) begin
            nxt.ph_write = hwrite;
            nxt.ph_addr = haddr[7:0];
            nxt.rdata = read_of(haddr[7:0], r, bus.mode, bus.lock, bus.clk_fast, bus.cm_ok);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r <= '0;
        end else begin
            r <= nxt;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = r.rdata;
    assign bus.hold_off = r.hold_off;

endmodule
`default_nettype wire

// file: rxpm_top.sv
// Purpose: operating mode controller and parity checked pixel bus of a serial video receiver
// Assumes: analog comparators and pll lock arrive as asynchronous levels
// Notes: the link clock is sampled by hclk, its edges found after two flops
//
// Our own choices: the register addresses and the AHB-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
// the map must precede the header, whose parameter defaults use its counts
`include "rxpm_map.svh"
module rxpm_top
    import rxpm_pkg::*;
#(
    parameter int EN_FILTER_CYC = `RXPM_EN_FILTER_CYC,
    parameter int ACTIVE_CYC = `RXPM_ACTIVE_CYC,
    parameter int STANDBY_CYC = `RXPM_STANDBY_CYC
)
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite register bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // control pins
    input wire logic receiver_enable_pin,
    input wire logic link_select_low,
    input wire logic link_select_high,
    // link side, all asynchronous
    input wire logic link_clock_pin,
    input wire logic cm_above_standby,
    input wire logic cm_below_active,
    input wire logic pll_lock_in,
    input wire logic [27:0] rx_word,
    // analog block controls
    output logic line_rx_enable,
    output logic pll_enable,
    output logic monitor_enable,
    output logic [4:0] pll_multiplier,
    // parallel pixel bus
    output logic [7:0] red_out,
    output logic [7:0] green_out,
    output logic [7:0] blue_out,
    output logic vertical_sync_out,
    output logic horizontal_sync_out,
    output logic display_enable_out,
    output logic pixel_clock_out,
    output logic parity_error_pulse
);

    rxpm_top_state_type r, nxt;
    rxpm_if bus ();

    logic rise;
    logic fall;
    logic en_req;
    logic standby_cond;
    logic wake;

    // lane count to pll factor; the reserved code falls back to one lane
    function automatic logic [4:0] mult_of(input logic [1:0] ls);
        logic [4:0] m;
        m = `RXPM_MULT_ONE_LANE;
        case (ls)
            2'h0: m = `RXPM_MULT_ONE_LANE;
            2'h1: m = `RXPM_MULT_TWO_LANE;
            2'h2: m = `RXPM_MULT_THREE_LANE;
            default: m = `RXPM_MULT_ONE_LANE;
        endcase
        return m;
    endfunction

    assign rise = r.clk_s2 & ~r.clk_d;
    assign fall = ~r.clk_s2 & r.clk_d;
    // software hold acts exactly like the pin going low
    assign en_req = r.en_s2 & ~bus.hold_off;
    assign standby_cond = r.cmh_s2 | r.clk_slow;
    assign wake = r.clk_fast & r.cml_s2 & ~r.cmh_s2;

    always_comb begin
        nxt = r;

        // synchronisers
        nxt.en_s1 = receiver_enable_pin;
        nxt.en_s2 = r.en_s1;
        nxt.clk_s1 = link_clock_pin;
        nxt.clk_s2 = r.clk_s1;
        nxt.clk_d = r.clk_s2;
        nxt.cmh_s1 = cm_above_standby;
        nxt.cmh_s2 = r.cmh_s1;
        nxt.cml_s1 = cm_below_active;
        nxt.cml_s2 = r.cml_s1;
        nxt.lock_s1 = pll_lock_in;
        nxt.lock_s2 = r.lock_s1;
        nxt.ls_s1 = {link_select_high, link_select_low};
        nxt.ls_s2 = r.ls_s1;
        nxt.word_s1 = rx_word;
        nxt.word_s2 = r.word_s1;

        // enable filter: a change counts only after it has stood over 10 us
        if (en_req != r.en_filt) begin
            if (r.en_cnt >= 12'(EN_FILTER_CYC)) begin
                nxt.en_filt = en_req;
                nxt.en_cnt = 12'h000;
            end else begin
                nxt.en_cnt = r.en_cnt + 12'h001;
            end
        end else begin
            nxt.en_cnt = 12'h000;
        end

        // clock activity monitor, idle in shutdown so the link is ignored
        if (r.mode == RXPM_SHUTDOWN) begin
            nxt.per_cnt = 10'h000;
            nxt.clk_fast = 1'b0;
            nxt.clk_slow = 1'b1;
        end else if (rise) begin
            // period under the 3 MHz limit counts as fast
            nxt.clk_fast = (r.per_cnt < 10'(ACTIVE_CYC));
            nxt.clk_slow = 1'b0;
            nxt.per_cnt = 10'h000;
        end else if (r.per_cnt >= 10'(STANDBY_CYC)) begin
            // no edge within a 500 kHz period
            nxt.clk_slow = 1'b1;
            nxt.clk_fast = 1'b0;
        end else begin
            nxt.per_cnt = r.per_cnt + 10'h001;
        end

        // pll factor is taken from the lane select pins
        nxt.mult = mult_of(r.ls_s2);

        // mode controller
        if (!r.en_filt) begin
            nxt.mode = RXPM_SHUTDOWN;
        end else begin
            case (r.mode)
                RXPM_SHUTDOWN: begin
                    nxt.mode = RXPM_STANDBY;
                end
                RXPM_STANDBY: begin
                    if (wake) begin
                        nxt.mode = RXPM_ACQUIRE;
                    end
                end
                RXPM_ACQUIRE: begin
                    // a 3 to 4 MHz clock may lock badly; nothing here can tell
                    if (standby_cond || !wake) begin
                        nxt.mode = RXPM_STANDBY;
                    end else if (r.lock_s2) begin
                        nxt.mode = RXPM_RECEIVE;
                    end
                end
                RXPM_RECEIVE: begin
                    if (standby_cond) begin
                        nxt.mode = RXPM_STANDBY;
                    end else if (!r.lock_s2) begin
                        nxt.mode = RXPM_ACQUIRE;
                    end
                end
                default: begin
                    nxt.mode = RXPM_SHUTDOWN;
                end
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r <= '0;
        end else begin
            r <= nxt;
        end
    end

    // carrier toward checker and registers
    assign bus.mode = r.mode;
    assign bus.lock = r.lock_s2;
    assign bus.clk_fast = r.clk_fast;
    assign bus.cm_ok = r.cml_s2 & ~r.cmh_s2;
    // checking and data only in receive, with clock and lock present
    assign bus.receive = (r.mode == RXPM_RECEIVE);
    assign bus.rise = rise;
    assign bus.fall = fall;
    assign bus.word = r.word_s2;

    rxpm_parity u_parity (
        .hclk(hclk),
        .hresetn(hresetn),
        .bus(bus)
    );

    rxpm_regs u_regs (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hready),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .hrdata(hrdata),
        .bus(bus)
    );

    // analog power controls follow the mode
    assign monitor_enable = (r.mode != RXPM_SHUTDOWN);
    assign pll_enable = (r.mode == RXPM_ACQUIRE) || (r.mode == RXPM_RECEIVE);
    assign line_rx_enable = pll_enable;
    assign pll_multiplier = r.mult;

    // pixel bus from checker flops, static pattern outside receive
    assign red_out = bus.pix[23:16];
    assign green_out = bus.pix[15:8];
    assign blue_out = bus.pix[7:0];
    assign vertical_sync_out = bus.pix[`RXPM_VS_BIT];
    assign horizontal_sync_out = bus.pix[`RXPM_HS_BIT];
    assign display_enable_out = bus.pix[`RXPM_DE_BIT];
    assign pixel_clock_out = bus.pclk;
    assign parity_error_pulse = bus.perr;

endmodule
`default_nettype wire

// file: rxpm_props.sv
// Purpose: port checks of the receive mode controller and parity checker
// Assumes: bound to rxpm_top, bench drives link inputs off the hclk edge
// Notes: helper counters saturate so long idle spans stay cheap
`timescale 1ns/10ps
`default_nettype none
module rxpm_props #(
    parameter int EN_FILTER_CYC = 2500,
    parameter int ACTIVE_CYC = 83,
    parameter int STANDBY_CYC = 500
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // inputs watched
    input wire logic receiver_enable_pin,
    input wire logic link_select_low,
    input wire logic link_select_high,
    input wire logic link_clock_pin,
    input wire logic cm_above_standby,
    input wire logic cm_below_active,
    // outputs watched
    input wire logic line_rx_enable,
    input wire logic pll_enable,
    input wire logic monitor_enable,
    input wire logic [4:0] pll_multiplier,
    input wire logic [7:0] red_out,
    input wire logic [7:0] green_out,
    input wire logic [7:0] blue_out,
    input wire logic vertical_sync_out,
    input wire logic horizontal_sync_out,
    input wire logic display_enable_out,
    input wire logic pixel_clock_out,
    input wire logic parity_error_pulse
);
    logic [15:0] lo_cnt_ff;
    logic [15:0] hi_cnt_ff;
    logic [15:0] idle_cnt_ff;
    logic lck_ff;
    logic [26:0] bus;
    assign bus = {display_enable_out, horizontal_sync_out, vertical_sync_out, red_out, green_out, blue_out};
    // cycles of steady enable level and of a still link clock
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lo_cnt_ff <= 16'h0000;
            hi_cnt_ff <= 16'h0000;
            idle_cnt_ff <= 16'h0000;
            lck_ff <= 1'b0;
        end else begin
            lo_cnt_ff <= receiver_enable_pin ? 16'h0000 : lo_cnt_ff + {15'h0000, ~&lo_cnt_ff};
            hi_cnt_ff <= receiver_enable_pin ? hi_cnt_ff + {15'h0000, ~&hi_cnt_ff} : 16'h0000;
            idle_cnt_ff <= (link_clock_pin != lck_ff) ? 16'h0000 : idle_cnt_ff + {15'h0000, ~&idle_cnt_ff};
            lck_ff <= link_clock_pin;
        end
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_perr_high;
        parity_error_pulse[*5];
    endsequence
    sequence s_perr_drop;
        !parity_error_pulse;
    endsequence
    // three cycles so the pattern loaded after reset release is already out
    property p_static;
        (!line_rx_enable)[*3] |-> bus == 27'h3FFFFFF && !pixel_clock_out;
    endproperty
    a_static: assert property (p_static) else $error("static pattern missing");
    property p_perr_len;
        $rose(parity_error_pulse) |-> s_perr_high ##[1:3] s_perr_drop;
    endproperty
    a_perr_len: assert property (p_perr_len) else $error("error pulse length wrong");
    property p_perr_hold;
        $rose(parity_error_pulse) |-> $stable(bus);
    endproperty
    a_perr_hold: assert property (p_perr_hold) else $error("bad word reached bus");
    property p_perr_mode;
        $rose(parity_error_pulse) |-> line_rx_enable && pll_enable;
    endproperty
    a_perr_mode: assert property (p_perr_mode) else $error("parity checked while idle");
    property p_mult;
        ($stable({link_select_high, link_select_low}))[*6] |-> pll_multiplier ==
            (link_select_low && !link_select_high ? 5'h0F : link_select_high && !link_select_low ? 5'h0A : 5'h1E);
    endproperty
    a_mult: assert property (p_mult) else $error("pll factor wrong");
    property p_sd_enter;
        lo_cnt_ff == EN_FILTER_CYC + 8 |-> !monitor_enable && !pll_enable && !line_rx_enable;
    endproperty
    a_sd_enter: assert property (p_sd_enter) else $error("no shutdown");
    property p_sd_hold;
        $fell(monitor_enable) |-> lo_cnt_ff > EN_FILTER_CYC;
    endproperty
    a_sd_hold: assert property (p_sd_hold) else $error("shutdown too early");
    property p_sd_leave;
        $rose(monitor_enable) |-> hi_cnt_ff > EN_FILTER_CYC;
    endproperty
    a_sd_leave: assert property (p_sd_leave) else $error("standby too early");
    property p_slow;
        idle_cnt_ff == STANDBY_CYC + 16 |-> !line_rx_enable;
    endproperty
    a_slow: assert property (p_slow) else $error("still active without clock");
    property p_cm;
        cm_above_standby[*5] |-> !line_rx_enable;
    endproperty
    a_cm: assert property (p_cm) else $error("active with high common mode");
    property p_wake;
        $rose(line_rx_enable) |-> receiver_enable_pin && cm_below_active && !cm_above_standby;
    endproperty
    a_wake: assert property (p_wake) else $error("woke without conditions");
endmodule
bind rxpm_top rxpm_props #(.EN_FILTER_CYC(EN_FILTER_CYC), .ACTIVE_CYC(ACTIVE_CYC), .STANDBY_CYC(STANDBY_CYC)) u_props (
    .hclk, .hresetn, .receiver_enable_pin, .link_select_low, .link_select_high, .link_clock_pin,
    .cm_above_standby, .cm_below_active, .line_rx_enable, .pll_enable, .monitor_enable, .pll_multiplier,
    .red_out, .green_out, .blue_out, .vertical_sync_out, .horizontal_sync_out, .display_enable_out,
    .pixel_clock_out, .parity_error_pulse
);
`default_nettype wire

// file: rxpm_tx_model.sv
// Purpose: serializing transmitter seen from the receiver pins
// Assumes: run and bad change on the bench clock edge
// Notes: clock stands still between frames, a stopped link floats its common mode high
`timescale 1ns/10ps
`default_nettype none
module rxpm_tx_model (
    // frame control
    input wire logic run,
    input wire logic bad,
    // link lanes
    output logic link_clock_pin,
    output logic cm_above_standby,
    output logic cm_below_active,
    output logic [27:0] rx_word,
    // last good payload sent
    output logic [26:0] exp_word
);
    logic [26:0] pay;
    initial begin
        link_clock_pin = 1'b0;
        rx_word = 28'h0000000;
        pay = 27'h0000000;
        exp_word = 27'h3FFFFFF;
    end
    assign cm_above_standby = !run;
    assign cm_below_active = run;
    // 48 ns period, well above the lowest active rate
    always begin
        #24;
        if (run) begin
            link_clock_pin = ~link_clock_pin;
        end
    end
    always @(posedge link_clock_pin) begin
        if (^rx_word) begin
            exp_word <= rx_word[26:0];
        end
        pay = pay + 27'h0ABCDEF;
        rx_word <= {~^pay ^ bad, pay};
    end
    // released lanes never keep showing the last word
    always @(negedge run) begin
        rx_word = ~rx_word;
    end
endmodule
`default_nettype wire

// file: testbench.sv
// Purpose: mode sequencing, parity handling and register access of rxpm_top
// Assumes: shortened enable filter and standby timeout
// Notes: pixel checks start two pixel clocks into receive, first word is not yet valid
`timescale 1ns/10ps
`default_nettype none
module testbench;
    localparam int EN_CYC = 20;
    logic hclk, hresetn, hwrite, hreadyout, hresp, rx_en, ls_lo, ls_hi, lock, run, bad, perr_q;
    logic lck, cm_hi, cm_lo, lre, pen, mon, vs, hs, de, pclk, perr;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata, rdat;
    logic [27:0] word;
    logic [26:0] exp_word, bus;
    logic [4:0] mult;
    logic [4:0] lm [4];
    logic [7:0] red, green, blue;
    int n_mismatch, checks, i;
    int n_perr = 0;
    assign bus = {de, hs, vs, red, green, blue};
    rxpm_top #(.EN_FILTER_CYC(EN_CYC), .ACTIVE_CYC(83), .STANDBY_CYC(100)) uut (
        .hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .receiver_enable_pin(rx_en), .link_select_low(ls_lo), .link_select_high(ls_hi),
        .link_clock_pin(lck), .cm_above_standby(cm_hi), .cm_below_active(cm_lo), .pll_lock_in(lock),
        .rx_word(word), .line_rx_enable(lre), .pll_enable(pen), .monitor_enable(mon), .pll_multiplier(mult),
        .red_out(red), .green_out(green), .blue_out(blue), .vertical_sync_out(vs), .horizontal_sync_out(hs),
        .display_enable_out(de), .pixel_clock_out(pclk), .parity_error_pulse(perr));
    rxpm_tx_model u_tx (.run(run), .bad(bad), .link_clock_pin(lck), .cm_above_standby(cm_hi),
        .cm_below_active(cm_lo), .rx_word(word), .exp_word(exp_word));
    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        perr_q <= perr;
        if (perr === 1'b1 && perr_q === 1'b0) n_perr <= n_perr + 1;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge hclk);
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rdat = hrdata;
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] exp, input logic [31:0] m);
        ahb(1'b0, a, 32'h00000000);
        chk(rdat & m, exp);
    endtask
    // bounded wait for a level on pclk, lre, mon
    task automatic wait_lvl(input int s, input logic v);
        int n;
        for (n = 0; n < 4000; n++) begin
            @(posedge hclk);
            if ((s == 0 ? pclk : s == 1 ? lre : mon) === v) break;
        end
        if (n == 4000) begin
            n_mismatch++;
            $display("Error t=%0t wait timeout got=%h exp=%h", $time, !v, v);
        end
    endtask
    task automatic watch(input int n);
        repeat (n) begin
            wait_lvl(0, 1'b0);
            wait_lvl(0, 1'b1);
            chk({5'h00, bus}, {5'h00, exp_word});
        end
    endtask
    task automatic idle_ok;
        chk({4'h0, pclk, bus}, {5'h00, 27'h3FFFFFF});
    endtask
    task automatic test_done;
        $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge hclk);
        n_mismatch++;
        test_done;
    end
    initial begin
        {hresetn, hwrite, rx_en, ls_lo, ls_hi, lock, run, bad, htrans} = '0;
        {haddr, hwdata, n_mismatch, checks} = '0;
        lm = '{5'h1E, 5'h0F, 5'h0A, 5'h1E};
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (3) @(posedge hclk);
        chk({pclk, mon, lre, hresp, hreadyout, bus}, {5'b00001, 27'h3FFFFFF});
        for (i = 0; i < 4; i++) begin
            {ls_hi, ls_lo} <= i[1:0];
            repeat (8) @(posedge hclk);
            chk({27'h0, mult}, {27'h0, lm[i]});
        end
        {ls_hi, ls_lo} <= 2'b00;
        ahb(1'b1, 32'h0, 32'h1);
        rd(32'h0, 32'h1, 32'hFFFFFFFF);
        ahb(1'b1, 32'h0, 32'h0);
        rd(32'hC, 32'h0, 32'hFFFFFFFF);
        run <= 1'b1;
        repeat (EN_CYC * 2) @(posedge hclk);
        chk({30'h0, mon, lre}, 32'h0);
        rx_en <= 1'b1;
        repeat (EN_CYC - 2) @(posedge hclk);
        chk({31'h0, mon}, 32'h0);
        wait_lvl(2, 1'b1);
        wait_lvl(1, 1'b1);
        rd(32'h4, 32'h1A, 32'h1F);
        repeat (4) @(posedge hclk);
        idle_ok();
        lock <= 1'b1;
        repeat (3) wait_lvl(0, ~pclk);
        ahb(1'b1, 32'h8, 32'h0);
        watch(3);
        bad <= 1'b1;
        watch(2);
        bad <= 1'b0;
        watch(3);
        rd(32'h8, 32'h2, 32'hFFFF);
        chk(n_perr, 32'h2);
        rd(32'h4, 32'h1F, 32'h1F);
        lock <= 1'b0;
        repeat (10) @(posedge hclk);
        rd(32'h4, 32'h2, 32'h3);
        idle_ok();
        lock <= 1'b1;
        wait_lvl(0, 1'b1);
        run <= 1'b0;
        wait_lvl(1, 1'b0);
        rd(32'h4, 32'h1, 32'h3);
        idle_ok();
        run <= 1'b1;
        wait_lvl(1, 1'b1);
        rx_en <= 1'b0;
        repeat (EN_CYC - 2) @(posedge hclk);
        chk({31'h0, mon}, 32'h1);
        wait_lvl(2, 1'b0);
        rd(32'h4, 32'h0, 32'h3);
        repeat (3) @(posedge hclk);
        idle_ok();
        test_done;
    end
endmodule
`default_nettype wire
